/* core/evp_arbiter.sv */
`timescale 1ns/100ps
`default_nettype none
`include "evp_map.svh"
module evp_arbiter
	import evp_pkg::*;
(
	// Pending causes
	input  wire logic       rst_req,
	input  wire logic       addr_err,
	input  wire logic       bus_err,
	input  wire logic       trace_req,
	input  wire logic       irq_ok,
	input  wire logic       illegal,
	input  wire logic       priv_viol,
	input  wire logic       line_a,
	input  wire logic       line_f,
	input  wire logic       call_req,
	input  wire logic [3:0] call_num,
	input  wire logic       overflow,
	input  wire logic       bounds,
	input  wire logic       zero_div,
	// Selection
	output var evp_cause_e  cause,
	output logic [7:0]      vector
);
	// First pending in fixed order wins: reset, address err, bus err, call, overflow, bounds, zero div, trace, irq, illegal, priv, line A, line F
	always_comb
	begin
		cause  = EVP_C_NONE;
		vector = 8'h00;
		if (rst_req)
		begin
			cause  = EVP_C_RESET;
			vector = `EVP_VEC_RESET;
		end
		else if (addr_err)
		begin
			cause  = EVP_C_ADDR_ERR;
			vector = `EVP_VEC_ADDR_ERR;
		end
		else if (bus_err)
		begin
			cause  = EVP_C_BUS_ERR;
			vector = `EVP_VEC_BUS_ERR;
		end
		else if (call_req)
		begin
			cause  = EVP_C_CALL;
			vector = `EVP_VEC_CALL_BASE + {4'h0, call_num};
		end
		else if (overflow)
		begin
			cause  = EVP_C_OVERFLOW;
			vector = `EVP_VEC_OVERFLOW;
		end
		else if (bounds)
		begin
			cause  = EVP_C_BOUNDS;
			vector = `EVP_VEC_BOUNDS;
		end
		else if (zero_div)
		begin
			cause  = EVP_C_ZERO_DIV;
			vector = `EVP_VEC_ZERO_DIV;
		end
		else if (trace_req)
		begin
			cause  = EVP_C_TRACE;
			vector = `EVP_VEC_TRACE;
		end
		else if (irq_ok)
		begin
			cause  = EVP_C_IRQ;
			vector = `EVP_VEC_UNINIT;
		end
		else if (illegal)
		begin
			cause  = EVP_C_ILLEGAL;
			vector = `EVP_VEC_ILLEGAL;
		end
		else if (priv_viol)
		begin
			cause  = EVP_C_PRIV;
			vector = `EVP_VEC_PRIV;
		end
		else if (line_a)
		begin
			cause  = EVP_C_LINE_A;
			vector = `EVP_VEC_LINE_A;
		end
		else if (line_f)
		begin
			cause  = EVP_C_LINE_F;
			vector = `EVP_VEC_LINE_F;
		end
	end
endmodule : evp_arbiter
`default_nettype wire

/* core/evp_map.svh */
`ifndef EVP_MAP_SVH
`define EVP_MAP_SVH
`define EVP_VEC_RESET      8'h00
`define EVP_VEC_BUS_ERR    8'h02
`define EVP_VEC_ADDR_ERR   8'h03
`define EVP_VEC_ILLEGAL    8'h04
`define EVP_VEC_ZERO_DIV   8'h05
`define EVP_VEC_BOUNDS     8'h06
`define EVP_VEC_OVERFLOW   8'h07
`define EVP_VEC_PRIV       8'h08
`define EVP_VEC_TRACE      8'h09
`define EVP_VEC_LINE_A     8'h0A
`define EVP_VEC_LINE_F     8'h0B
`define EVP_VEC_UNINIT     8'h0F
`define EVP_VEC_SPURIOUS   8'h18
`define EVP_VEC_CALL_BASE  8'h20
`define EVP_VEC_USER_FIRST 8'h40
`define EVP_RESET_PC_OFS   32'h0000_0004
`define EVP_BASE_RESET     32'h0000_0000
`define EVP_MASK_RESET     3'h7
`define EVP_SR_S_BIT       13
`define EVP_SR_T_BIT       15
`define EVP_SR_MASK_LSB    8
`define EVP_CLASS_USER_D   3'h1
`define EVP_CLASS_USER_P   3'h2
`define EVP_CLASS_SUP_D    3'h5
`define EVP_CLASS_SUP_P    3'h6
`define EVP_CLASS_CPU      3'h7
`endif

/* core/evp_pkg.sv */
package evp_pkg;
	typedef enum logic [3:0] {
		EVP_C_NONE     = 4'h0,
		EVP_C_RESET    = 4'h1,
		EVP_C_ADDR_ERR = 4'h2,
		EVP_C_BUS_ERR  = 4'h3,
		EVP_C_TRACE    = 4'h4,
		EVP_C_IRQ      = 4'h5,
		EVP_C_ILLEGAL  = 4'h6,
		EVP_C_PRIV     = 4'h7,
		EVP_C_LINE_A   = 4'h8,
		EVP_C_LINE_F   = 4'h9,
		EVP_C_CALL     = 4'hA,
		EVP_C_OVERFLOW = 4'hB,
		EVP_C_BOUNDS   = 4'hC,
		EVP_C_ZERO_DIV = 4'hD
	} evp_cause_e;

	typedef enum logic [2:0] {
		EVP_S_IDLE  = 3'h0,
		EVP_S_IACK  = 3'h1,
		EVP_S_FETCH = 3'h2,
		EVP_S_FETCH2 = 3'h3,
		EVP_S_DONE  = 3'h4
	} evp_state_e;
endpackage : evp_pkg

/* core/evp_unit.sv */
`timescale 1ns/100ps
`default_nettype none
`include "evp_map.svh"
module evp_unit
	import evp_pkg::*;
#(
	parameter bit HAS_BASE = 1'b1
)
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// Pipeline causes
	input  wire logic        boundary,
	input  wire logic        addr_err,
	input  wire logic        bus_err,
	input  wire logic        trace_en,
	input  wire logic        illegal,
	input  wire logic        priv_viol,
	input  wire logic        line_a,
	input  wire logic        line_f,
	input  wire logic        call_req,
	input  wire logic [3:0]  call_num,
	input  wire logic        overflow,
	input  wire logic        bounds,
	input  wire logic        zero_div,
	// Status word
	input  wire logic [15:0] status_in,
	// Base register write
	input  wire logic        base_we,
	input  wire logic [31:0] base_wdata,
	// External bus pins
	input  wire logic [2:0]  irq_level_pin,
	input  wire logic [15:0] data_pin,
	input  wire logic        iack_vec_pin,
	input  wire logic        iack_auto_pin,
	input  wire logic        iack_berr_pin,
	input  wire logic        fetch_done_pin,
	// Bus outputs
	output logic [23:1]      addr_out,
	output logic [2:0]       access_class_lines,
	output logic             bus_req,
	output logic             iack_cycle,
	// Sequencer outputs
	output logic             abort_instr,
	output logic             exc_start,
	output logic [7:0]       exc_vector,
	output logic [31:0]      vector_addr,
	output logic [15:0]      saved_status,
	output logic [15:0]      status_out,
	output logic             status_we,
	output logic [31:0]      vector_base,
	output logic             busy
);
	// Reset release through two flops
	logic rst_s1_ff, rst_s2_ff;
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end
		else
		begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end
	wire logic rst_n = rst_s2_ff;

	// Pin synchronisers; first stage read only by second
	logic [21:0] pin_s1_ff, pin_s2_ff;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_ff <= 22'h000000;
			pin_s2_ff <= 22'h000000;
		end
		else
		begin
			pin_s1_ff <= {irq_level_pin, data_pin[7:0], iack_vec_pin,
				iack_auto_pin, iack_berr_pin, fetch_done_pin, 7'h00};
			pin_s2_ff <= pin_s1_ff;
		end
	end
	wire logic [2:0] irq_lvl   = pin_s2_ff[21:19];
	wire logic [7:0] ext_vec   = pin_s2_ff[18:11];
	wire logic       ack_vec   = pin_s2_ff[10];
	wire logic       ack_auto  = pin_s2_ff[9];
	wire logic       ack_berr  = pin_s2_ff[8];
	wire logic       fetch_ok  = pin_s2_ff[7];

	// Offset and address forming, used for every first fetch word; the reset second word adds 4 instead
	function automatic logic [31:0] vec_addr(input logic [7:0] v,
		input logic [31:0] base);
		logic [31:0] ofs;
		ofs = {22'h000000, v, 2'b00};
		vec_addr = HAS_BASE ? base + ofs : ofs;
	endfunction : vec_addr

	// Interrupt mask gate
	logic [2:0] mask;
	assign mask = status_in[`EVP_SR_MASK_LSB+2:`EVP_SR_MASK_LSB];
	wire logic irq_ok = (irq_lvl > mask) && boundary;

	// Group 0 needs no boundary; group 1 waits for it
	logic       boot_ff, nxt_boot;
	evp_cause_e cause;
	logic [7:0] arb_vec;
	evp_arbiter u_arb (
		.rst_req   (boot_ff),
		.addr_err  (addr_err),
		.bus_err   (bus_err),
		.trace_req (trace_en && boundary),
		.irq_ok    (irq_ok),
		.illegal   (illegal && boundary),
		.priv_viol (priv_viol && boundary),
		.line_a    (line_a && boundary),
		.line_f    (line_f && boundary),
		.call_req  (call_req),
		.call_num  (call_num),
		.overflow  (overflow),
		.bounds    (bounds),
		.zero_div  (zero_div),
		.cause     (cause),
		.vector    (arb_vec)
	);

	evp_state_e state_ff, nxt_state;
	logic [7:0]  vec_ff, nxt_vec;
	logic [31:0] base_ff, nxt_base;
	logic [31:0] vaddr_ff, nxt_vaddr;
	logic [2:0]  class_ff, nxt_class;
	logic [2:0]  lvl_ff, nxt_lvl;
	logic [15:0] sav_ff, nxt_sav;
	logic [15:0] sout_ff, nxt_sout;
	logic        swe_ff, nxt_swe;
	logic        abort_ff, nxt_abort;
	logic        start_ff, nxt_start;
	logic        breq_ff, nxt_breq;
	logic        is_reset_ff, nxt_is_reset;
	logic        iack_ff, nxt_iack;
	logic        busy_ff, nxt_busy;

	always_comb
	begin
		nxt_state    = state_ff;
		nxt_vec      = vec_ff;
		nxt_base     = base_ff;
		nxt_vaddr    = vaddr_ff;
		nxt_class    = class_ff;
		nxt_lvl      = lvl_ff;
		nxt_sav      = sav_ff;
		nxt_sout     = sout_ff;
		nxt_swe      = 1'b0;
		nxt_abort    = 1'b0;
		nxt_start    = 1'b0;
		nxt_breq     = breq_ff;
		nxt_is_reset = is_reset_ff;
		nxt_boot     = 1'b0;
		if (base_we && HAS_BASE)
			nxt_base = base_wdata;
		unique case (state_ff)
			EVP_S_IDLE:
			begin
				if (boot_ff)
				begin
					// Reset sequence: everything else dropped
					nxt_vec      = `EVP_VEC_RESET;
					nxt_is_reset = 1'b1;
					nxt_vaddr    = vec_addr(`EVP_VEC_RESET, nxt_base);
					nxt_class    = `EVP_CLASS_SUP_P;
					nxt_sout     = status_in;
					nxt_sout[`EVP_SR_S_BIT] = 1'b1;
					nxt_sout[`EVP_SR_T_BIT] = 1'b0;
					nxt_sout[`EVP_SR_MASK_LSB+2:`EVP_SR_MASK_LSB] =
						`EVP_MASK_RESET;
					nxt_swe      = 1'b1;
					nxt_start    = 1'b1;
					nxt_breq     = 1'b1;
					nxt_state    = EVP_S_FETCH;
				end
				else if (cause != EVP_C_NONE)
				begin
					// One cycle from cause to start
					nxt_abort    = (cause == EVP_C_ADDR_ERR) ||
						(cause == EVP_C_BUS_ERR);
					nxt_sav      = status_in;
					nxt_sout     = status_in;
					nxt_sout[`EVP_SR_S_BIT] = 1'b1;
					nxt_sout[`EVP_SR_T_BIT] = 1'b0;
					nxt_swe      = 1'b1;
					nxt_start    = 1'b1;
					nxt_is_reset = 1'b0;
					nxt_vec      = arb_vec;
					if (cause == EVP_C_IRQ)
					begin
						nxt_lvl   = irq_lvl;
						nxt_sout[`EVP_SR_MASK_LSB+2:`EVP_SR_MASK_LSB] =
							irq_lvl;
						nxt_class = `EVP_CLASS_CPU;
						nxt_vaddr = {28'h0000000, irq_lvl, 1'b1};
						nxt_breq  = 1'b1;
						nxt_state = EVP_S_IACK;
					end
					else
					begin
						nxt_vaddr = vec_addr(arb_vec, nxt_base);
						nxt_class = `EVP_CLASS_SUP_D;
						nxt_breq  = 1'b1;
						nxt_state = EVP_S_FETCH;
					end
				end
			end
			EVP_S_IACK:
			begin
				if (ack_berr)
					nxt_vec = `EVP_VEC_SPURIOUS;
				else if (ack_auto)
					nxt_vec = `EVP_VEC_SPURIOUS + {5'h00, lvl_ff};
				else if (ack_vec)
					nxt_vec = ext_vec;
				if (ack_berr || ack_auto || ack_vec)
				begin
					nxt_vaddr = vec_addr(nxt_vec, base_ff);
					nxt_class = `EVP_CLASS_SUP_D;
					nxt_state = EVP_S_FETCH;
				end
			end
			EVP_S_FETCH:
			begin
				if (fetch_ok)
				begin
					if (is_reset_ff)
					begin
						// Second half: initial PC at byte 4
						nxt_vaddr = vaddr_ff + `EVP_RESET_PC_OFS;
						nxt_state = EVP_S_FETCH2;
					end
					else
					begin
						nxt_breq  = 1'b0;
						nxt_state = EVP_S_DONE;
					end
				end
			end
			EVP_S_FETCH2:
			begin
				if (fetch_ok)
				begin
					nxt_breq  = 1'b0;
					nxt_state = EVP_S_DONE;
				end
			end
			EVP_S_DONE:
				nxt_state = EVP_S_IDLE;
			default:
				nxt_state = EVP_S_IDLE;
		endcase
		if (!breq_ff && !nxt_breq)
			nxt_class = `EVP_CLASS_SUP_D;
		// Registered so the bus never sees a decode glitch
		nxt_iack = (nxt_state == EVP_S_IACK);
		nxt_busy = (nxt_state != EVP_S_IDLE);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff    <= EVP_S_IDLE;
			vec_ff      <= 8'h00;
			base_ff     <= `EVP_BASE_RESET;
			vaddr_ff    <= 32'h0000_0000;
			class_ff    <= `EVP_CLASS_SUP_P;
			lvl_ff      <= 3'h0;
			sav_ff      <= 16'h0000;
			sout_ff     <= 16'h0000;
			swe_ff      <= 1'b0;
			abort_ff    <= 1'b0;
			start_ff    <= 1'b0;
			breq_ff     <= 1'b0;
			is_reset_ff <= 1'b0;
			boot_ff     <= 1'b1;
			iack_ff     <= 1'b0;
			busy_ff     <= 1'b0;
		end
		else
		begin
			state_ff    <= nxt_state;
			vec_ff      <= nxt_vec;
			base_ff     <= nxt_base;
			vaddr_ff    <= nxt_vaddr;
			class_ff    <= nxt_class;
			lvl_ff      <= nxt_lvl;
			sav_ff      <= nxt_sav;
			sout_ff     <= nxt_sout;
			swe_ff      <= nxt_swe;
			abort_ff    <= nxt_abort;
			start_ff    <= nxt_start;
			breq_ff     <= nxt_breq;
			is_reset_ff <= nxt_is_reset;
			boot_ff     <= nxt_boot;
			iack_ff     <= nxt_iack;
			busy_ff     <= nxt_busy;
		end
	end

	// Bit 0 left to the data strobes
	assign addr_out           = vaddr_ff[23:1];
	assign access_class_lines = class_ff;
	assign bus_req            = breq_ff;
	assign iack_cycle         = iack_ff;
	assign abort_instr        = abort_ff;
	assign exc_start          = start_ff;
	assign exc_vector         = vec_ff;
	assign vector_addr        = vaddr_ff;
	assign saved_status       = sav_ff;
	assign status_out         = sout_ff;
	assign status_we          = swe_ff;
	assign vector_base        = base_ff;
	assign busy               = busy_ff;
endmodule : evp_unit
`default_nettype wire

/* sim/evp_far_end.sv */
`timescale 1ns/100ps
`default_nettype none
module evp_far_end (
	// Bus side
	input  wire logic        mclk,
	input  wire logic        bus_req,
	input  wire logic        iack_cycle,
	input  wire logic [23:1] addr_out,
	// Scenario controls
	input  wire logic [1:0]  ack_kind,
	input  wire logic [7:0]  ack_vec,
	input  wire logic [3:0]  ack_delay,
	// Answers
	output logic      [15:0] data_pin,
	output logic             iack_vec_pin,
	output logic             iack_auto_pin,
	output logic             iack_berr_pin,
	output logic             fetch_done_pin
);
	logic [3:0]  wait_ff = 4'h0;
	logic        done_ff = 1'b0;
	logic [23:1] last_ff = 23'h0;
	initial
	begin
		data_pin = 16'h0000;
		{iack_vec_pin, iack_auto_pin, iack_berr_pin} = 3'h0;
		fetch_done_pin = 1'b0;
	end
	// Released lines toggle so a stale vector is never read
	always @(posedge mclk)
	begin
		fetch_done_pin <= 1'b0;
		if (!iack_cycle)
		begin
			{iack_vec_pin, iack_auto_pin, iack_berr_pin} <= 3'h0;
			data_pin <= ~data_pin;
		end
		wait_ff <= (bus_req && !done_ff) ? wait_ff + 4'h1 : 4'h0;
		done_ff <= done_ff && bus_req && addr_out == last_ff;
		if (bus_req && !done_ff && wait_ff >= ack_delay)
		begin
			done_ff <= 1'b1;
			last_ff <= addr_out;
			fetch_done_pin <= !iack_cycle;
			if (iack_cycle)
			begin
				data_pin <= {8'hA5, ack_vec};
				iack_vec_pin <= ack_kind == 2'h0;
				iack_auto_pin <= ack_kind == 2'h1;
				iack_berr_pin <= ack_kind == 2'h2;
			end
		end
	end
endmodule : evp_far_end
`default_nettype wire

/* sim/evp_unit_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module evp_unit_chk (
	// Clock, reset, causes and status word
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic        addr_err,
	input wire logic        bus_err,
	input wire logic [15:0] status_in,
	// Observed outputs
	input wire logic [23:1] addr_out,
	input wire logic [2:0]  access_class_lines,
	input wire logic        bus_req,
	input wire logic        iack_cycle,
	input wire logic        abort_instr,
	input wire logic        exc_start,
	input wire logic [7:0]  exc_vector,
	input wire logic [31:0] vector_addr,
	input wire logic [15:0] status_out,
	input wire logic        status_we,
	input wire logic [31:0] vector_base,
	input wire logic        busy
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	wire fetch_d = bus_req && access_class_lines == 3'h5;
	wire fetch_v = fetch_d || bus_req && access_class_lines == 3'h6;
	a_vec_offset: assert property (
		fetch_d |-> vector_addr == vector_base + {22'h0, exc_vector, 2'h0})
		else $error("vector address wrong");
	a_addr_trunc: assert property (
		fetch_d |-> addr_out == vector_addr[23:1])
		else $error("bus address wrong");
	a_space_sel: assert property (
		fetch_v |-> (access_class_lines == 3'h6) == (exc_vector == 8'h00))
		else $error("vector space wrong");
	a_iack_space: assert property (
		iack_cycle |-> access_class_lines == 3'h7 && bus_req)
		else $error("acknowledge space wrong");
	a_grp0_start: assert property (
		$rose(addr_err || bus_err) && !busy |-> ##[1:2] abort_instr && exc_start)
		else $error("group 0 start late");
	a_entry_stat: assert property (
		exc_start |-> status_we && status_out[13] && !status_out[15])
		else $error("entry status wrong");
	a_irq_level: assert property (
		$rose(iack_cycle) |-> addr_out[3:1] > status_in[10:8])
		else $error("masked level taken");
	a_start_pulse: assert property (
		exc_start |=> !exc_start && busy)
		else $error("start not a pulse");
	c_iack: cover property (iack_cycle);
	c_abort: cover property (abort_instr);
	c_reset_fetch: cover property (bus_req && access_class_lines == 3'h6);
endmodule : evp_unit_chk
bind evp_unit evp_unit_chk i_evp_unit_chk (
	.mclk               (mclk),
	.nrst               (nrst),
	.addr_err           (addr_err),
	.bus_err            (bus_err),
	.status_in          (status_in),
	.addr_out           (addr_out),
	.access_class_lines (access_class_lines),
	.bus_req            (bus_req),
	.iack_cycle         (iack_cycle),
	.abort_instr        (abort_instr),
	.exc_start          (exc_start),
	.exc_vector         (exc_vector),
	.vector_addr        (vector_addr),
	.status_out         (status_out),
	.status_we          (status_we),
	.vector_base        (vector_base),
	.busy               (busy)
);
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        boundary = 1'b1;
	logic [10:0] cz = 11'h000;
	logic [3:0]  call_num = 4'hF;
	logic [15:0] status_in = 16'h0000;
	logic        base_we = 1'b0;
	logic [31:0] base_wdata = 32'h0000_0000;
	logic [2:0]  irq_level_pin = 3'h0;
	logic [1:0]  ack_kind = 2'h0;
	logic [7:0]  ack_vec = 8'h40;
	logic [3:0]  ack_delay = 4'h0;
	logic [31:0] exp_base = 32'h0000_0000;
	logic [7:0]  ev [11] = '{8'h05, 8'h06, 8'h07, 8'h2F, 8'h02, 8'h03,
		8'h0B, 8'h0A, 8'h08, 8'h04, 8'h09};
	int          error_cnt = 0;
	int          num_checks = 0;
	wire         trace_en, illegal, priv_viol, line_a, line_f, addr_err;
	wire         bus_err, call_req, overflow, bounds, zero_div;
	wire         iack_vec_pin, iack_auto_pin, iack_berr_pin, fetch_done_pin;
	wire         bus_req, iack_cycle, abort_instr, exc_start, status_we, busy;
	wire [15:0]  data_pin, saved_status, status_out;
	wire [23:1]  addr_out;
	wire [2:0]   access_class_lines;
	wire [7:0]   exc_vector;
	wire [31:0]  vector_addr, vector_base;
	assign {trace_en, illegal, priv_viol, line_a, line_f, addr_err,
		bus_err, call_req, overflow, bounds, zero_div} = cz;
	evp_unit i_evp_unit (
		.mclk               (mclk),
		.nrst               (nrst),
		.boundary           (boundary),
		.addr_err           (addr_err),
		.bus_err            (bus_err),
		.trace_en           (trace_en),
		.illegal            (illegal),
		.priv_viol          (priv_viol),
		.line_a             (line_a),
		.line_f             (line_f),
		.call_req           (call_req),
		.call_num           (call_num),
		.overflow           (overflow),
		.bounds             (bounds),
		.zero_div           (zero_div),
		.status_in          (status_in),
		.base_we            (base_we),
		.base_wdata         (base_wdata),
		.irq_level_pin      (irq_level_pin),
		.data_pin           (data_pin),
		.iack_vec_pin       (iack_vec_pin),
		.iack_auto_pin      (iack_auto_pin),
		.iack_berr_pin      (iack_berr_pin),
		.fetch_done_pin     (fetch_done_pin),
		.addr_out           (addr_out),
		.access_class_lines (access_class_lines),
		.bus_req            (bus_req),
		.iack_cycle         (iack_cycle),
		.abort_instr        (abort_instr),
		.exc_start          (exc_start),
		.exc_vector         (exc_vector),
		.vector_addr        (vector_addr),
		.saved_status       (saved_status),
		.status_out         (status_out),
		.status_we          (status_we),
		.vector_base        (vector_base),
		.busy               (busy)
	);
	evp_far_end i_evp_far_end (
		.mclk           (mclk),
		.bus_req        (bus_req),
		.iack_cycle     (iack_cycle),
		.addr_out       (addr_out),
		.ack_kind       (ack_kind),
		.ack_vec        (ack_vec),
		.ack_delay      (ack_delay),
		.data_pin       (data_pin),
		.iack_vec_pin   (iack_vec_pin),
		.iack_auto_pin  (iack_auto_pin),
		.iack_berr_pin  (iack_berr_pin),
		.fetch_done_pin (fetch_done_pin)
	);
	always #10 mclk = ~mclk;
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Bounded poll: 0 start, 1 idle, 2 data-space fetch, 3 second word
	task automatic wt(input int sel);
		for (int n = 0; n < 300; n++)
		begin
			if (sel == 0 && exc_start === 1'b1 || sel == 1 && busy === 1'b0
				|| sel == 2 && bus_req === 1'b1 && access_class_lines === 3'h5
				|| sel == 3 && addr_out === 23'h2)
				return;
			@(negedge mclk);
		end
		error_cnt++;
		$display("CHECK FAILED t=%0t wait %0d timed out", $time, sel);
		complete_run();
	endtask : wt
	task automatic fin(input logic [7:0] v);
		logic [31:0] a;
		a = exp_base + {22'h0, v, 2'h0};
		wt(2);
		chk(exc_vector, v);
		chk(vector_addr, a);
		chk(addr_out, a[23:1]);
	endtask : fin
	task automatic run(input logic [10:0] c, input logic [7:0] v);
		wt(1);
		cz = c;
		@(negedge mclk);
		cz = 11'h000;
		// Start stands one cycle only: look now, not a cycle later
		chk(exc_start, 1'b1);
		chk(abort_instr, c[5] | c[4]);
		chk(status_we, 1'b1);
		chk({status_out[15], status_out[13]}, 2'h1);
		chk(saved_status, status_in);
		fin(v);
	endtask : run
	task automatic t_reset();
		wt(0);
		chk(exc_vector, 8'h00);
		chk(access_class_lines, 3'h6);
		chk({status_out[15], status_out[13], status_out[10:8]}, 5'h0F);
		chk(addr_out, 23'h0);
		wt(3);
		chk(access_class_lines, 3'h6);
		wt(1);
		chk(vector_base, 32'h0);
	endtask : t_reset
	task automatic t_prio();
		status_in = 16'h8000;
		for (int i = 0; i < 11; i++)
			run(11'h001 << i, ev[i]);
		run(11'h030, 8'h03);
		run(11'h018, 8'h02);
		wt(1);
		cz = 11'h408;
		@(negedge mclk);
		cz = 11'h400;
		fin(8'h2F);
		wt(1);
		fin(8'h09);
		cz = 11'h000;
		boundary = 1'b0;
		run(11'h020, 8'h03);
		wt(1);
		cz = 11'h200;
		repeat (10)
		begin
			@(negedge mclk);
			chk(exc_start, 1'b0);
		end
		boundary = 1'b1;
		wt(0);
		cz = 11'h000;
		fin(8'h04);
	endtask : t_prio
	task automatic t_base();
		wt(1);
		base_wdata = 32'hAB00_1000;
		base_we = 1'b1;
		@(negedge mclk);
		base_we = 1'b0;
		exp_base = 32'hAB00_1000;
		@(negedge mclk);
		chk(vector_base, exp_base);
		run(11'h002, 8'h06);
	endtask : t_base
	task automatic t_irq(input logic [2:0] lv, input logic [1:0] k,
		input logic [7:0] v, input logic [7:0] e);
		wt(1);
		ack_kind = k;
		ack_vec = v;
		irq_level_pin = lv;
		wt(0);
		irq_level_pin = 3'h0;
		chk(iack_cycle, 1'b1);
		chk(addr_out[3:1], lv);
		chk(saved_status, status_in);
		chk(status_out[10:8], lv);
		fin(e);
	endtask : t_irq
	task automatic t_mask();
		status_in = 16'h0300;
		irq_level_pin = 3'h3;
		for (int n = 0; n < 20; n++)
		begin
			@(negedge mclk);
			chk(exc_start, 1'b0);
		end
		t_irq(3'h4, 2'h0, 8'h40, 8'h40);
		t_irq(3'h6, 2'h0, 8'hFF, 8'hFF);
		t_irq(3'h7, 2'h1, 8'h00, 8'h1F);
		ack_delay = 4'h9;
		t_irq(3'h5, 2'h2, 8'h00, 8'h18);
	endtask : t_mask
	// Reset in mid-fetch with trace held and a nonzero base
	task automatic t_rerst();
		cz = 11'h400;
		wt(0);
		nrst = 1'b0;
		@(negedge mclk);
		nrst = 1'b1;
		t_reset();
		exp_base = 32'h0000_0000;
		fin(8'h09);
		cz = 11'h000;
	endtask : t_rerst
	initial
	begin
		repeat (5) @(negedge mclk);
		nrst = 1'b1;
		t_reset();
		t_prio();
		t_base();
		t_mask();
		t_rerst();
		complete_run();
	end
endmodule : tb
`default_nettype wire
